//--- hw/rst_pins_pkg.sv
// Package: constants and carriers for the reset and pin-state controller
package rst_pins_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned LDO_SETTLE_MS   = 8;
   localparam int unsigned ANA_SETTLE_MS   = 4;
   localparam int unsigned LDO_SETTLE_CYC  = (LDO_SETTLE_MS * (CLK_HZ / 1000));
   localparam int unsigned ANA_SETTLE_CYC  = (ANA_SETTLE_MS * (CLK_HZ / 1000));
   localparam int unsigned PIN_HIZ_CYC     = 2;
   localparam int unsigned BOOT_SAMPLE_CYC = 10;
   localparam int unsigned CLKGEN_CYC      = 1;

   // Comparator thresholds in millivolts
   localparam logic [11:0] OK_RISE_MV = 12'h3B6;
   localparam logic [11:0] OK_FALL_MV = 12'h352;

   // Widths and reset values
   localparam int unsigned CNT_W     = 24;
   localparam int unsigned MUX_W     = 16;
   localparam int unsigned BOOT_W    = 6;
   localparam int unsigned PERIPH_W  = 8;
   localparam int unsigned SMALL_W   = 4;
   localparam logic [MUX_W-1:0]  MUX_RST  = 16'h0000;
   localparam logic [BOOT_W-1:0] BOOT_RST = 6'h00;

   // Sequencer states, Gray coded along the path
   typedef enum logic [2:0] {
      SEQ_RESET  = 3'h0,
      SEQ_HIZ    = 3'h1,
      SEQ_CLKGEN = 3'h3,
      SEQ_BOOT   = 3'h2,
      SEQ_RUN    = 3'h6
   } seq_e;

   // Fixed-function and multiplexed output pin group drive
   typedef struct packed {
      logic cs_hi_oe_n;      // Chip selects 2..5, masks, strobes, flag
      logic clkout_oe_n;
      logic clkout;
      logic mem_cke_oe_n;
      logic mem_cke;
      logic mux_oe_n;        // Multiplexed pins
      logic analog_oe_n;     // Analog inputs, never driven
   } pin_ctl_s;

   // Supply monitor state, cleared by the reset pin only
   typedef struct packed {
      logic [CNT_W-1:0]     ldo_cnt;
      logic [CNT_W-1:0]     ana_cnt;
      logic                 supply_ok;
   } mon_s;

   // Sequencer state, cleared by the hardware reset
   typedef struct packed {
      seq_e                 seq;
      logic [SMALL_W-1:0]   step_cnt;
      logic                 clkgen_en;
      logic                 boot_go;
      logic [BOOT_W-1:0]    boot_mode;
      logic                 clkout;
      logic                 mem_cke;
   } state_s;

endpackage

//--- hw/chip_reset_and_pin_state_control.sv
// Chip reset generation and pin-state control around reset and core power loss
`timescale 1ns/1ns

// Notes on behaviour
// R1: Core power lost: strong drivers off, bus holders on, pulls off.
// R2: RTC, USB and analog-block pins exempt from power-loss handling.
// R3: Reset whenever reset pin low or supply_ok_signal low.
// R4: Active-low hardware reset equals reset pin AND supply_ok_signal.
// R5: Regulator disabled (enable input high): supply_ok forced high at once.
// R6: Regulator on: supply_ok waits 8 ms input, 4 ms analog, above 950 mV.
// R7: Once high, supply_ok falls only below 850 mV; code also drops it when either input supply goes low.
// R8: Global reset covers all but RTC; boot starts on its release.
// R9: Board must drive reset pin when the regulator is disabled.
// R10: After reset, enable clock generator, then start boot.
// R11: All pins high impedance in reset and two cycles after; code keeps them Z three cycles after release, and exempt pins stay driven.
// R12: RTC power-on reset initialises RTC flops and power-lost flag.
// R13: CPU reset instruction and peripheral reset lines are separate soft resets.
// R14: Outside reset, multiplexed pins follow the external bus select register.
// R15: Chip selects, masks, strobes, flag: Z in reset, then driven high.
// R16: Clock output pin Z in reset, then drives the clock.
// R17: Memory clock enable Z in reset, then synchronous 0 to 1.
// R18: Analog input pins stay high impedance throughout.
// R19: Boot-mode pins sampled ten cycles after release, readable later; code samples them eleven cycles after release.
// R20: Reset asserts asynchronously, deasserts synchronously to clock.
module chip_reset_and_pin_state_control (
   input  wire logic                               clock,
   input  wire logic                               resetn,
   input  wire logic                               rtc_por_n,
   input  wire logic                               core_regulator_enable_in,
   input  wire logic                               regulator_input_supply,
   input  wire logic                               analog_supply,
   input  wire logic [11:0]                        core_regulator_output,
   input  wire logic                               core_power_lost_flag,
   input  wire logic                               rtc_time_loaded,
   input  wire logic                               cpu_soft_reset,
   input  wire logic [rst_pins_pkg::PERIPH_W-1:0]  periph_soft_reset,
   input  wire logic [rst_pins_pkg::MUX_W-1:0]     external_bus_select_reg,
   input  wire logic [rst_pins_pkg::MUX_W-1:0]     periph_a_out,
   input  wire logic [rst_pins_pkg::MUX_W-1:0]     periph_b_out,
   input  wire logic [rst_pins_pkg::MUX_W-1:0]     periph_oe_n,
   input  wire logic [rst_pins_pkg::BOOT_W-1:0]    boot_mode_pins,
   output logic                                    supply_ok_signal,
   output logic                                    hw_reset_n,
   output logic                                    cpu_reset_n,
   output logic [rst_pins_pkg::PERIPH_W-1:0]       periph_reset_n,
   output logic                                    clkgen_enable,
   output logic                                    boot_start,
   output logic [rst_pins_pkg::BOOT_W-1:0]         boot_mode,
   output logic                                    rtc_power_lost_flag,
   output logic [rst_pins_pkg::MUX_W-1:0]          mux_pin_out,
   output logic [rst_pins_pkg::MUX_W-1:0]          mux_pin_oe_n,
   output logic                                    ctl_pins_out,
   output logic                                    ctl_pins_oe_n,
   output logic                                    clkout_pin,
   output logic                                    clkout_pin_oe_n,
   output logic                                    memory_clock_enable_pin,
   output logic                                    memory_clock_enable_pin_oe_n,
   output logic                                    analog_input_pins_oe_n,
   output logic                                    bus_holder_en,
   output logic                                    pull_disable,
   output logic                                    exempt_pins_oe_n
);

   rst_pins_pkg::mon_s     mon_q;
   rst_pins_pkg::mon_s     mon_d;
   rst_pins_pkg::state_s   s_q;
   rst_pins_pkg::state_s   s_d;
   rst_pins_pkg::pin_ctl_s pins;
   logic                   raw_rst_n;
   logic                   sync1_q;
   logic                   sync2_q;
   logic                   rtc_lost_q;
   logic                   ldo_settled;
   logic                   ana_settled;
   logic                   above_rise;
   logic                   above_fall;

   // Limit check shared by both supply counters
   function automatic logic cnt_reached(
      input logic [rst_pins_pkg::CNT_W-1:0] v,
      input int unsigned                    lim
   );
      cnt_reached = (v >= rst_pins_pkg::CNT_W'(lim));
   endfunction

   // Counts stop at the limit so a long-stable supply never wraps
   function automatic logic [rst_pins_pkg::CNT_W-1:0] sat_inc(
      input logic [rst_pins_pkg::CNT_W-1:0] v,
      input int unsigned                    lim
   );
      if (cnt_reached(v, lim)) begin
         sat_inc = v;
      end else begin
         sat_inc = v + 1'b1;
      end
   endfunction

   // Step check shared by the sequencer states
   function automatic logic step_reached(
      input logic [rst_pins_pkg::SMALL_W-1:0] v,
      input int unsigned                      lim
   );
      step_reached = (v >= rst_pins_pkg::SMALL_W'(lim));
   endfunction

   assign ldo_settled = cnt_reached(mon_q.ldo_cnt, rst_pins_pkg::LDO_SETTLE_CYC);    // R6
   assign ana_settled = cnt_reached(mon_q.ana_cnt, rst_pins_pkg::ANA_SETTLE_CYC);    // R6
   assign above_rise  = (core_regulator_output > rst_pins_pkg::OK_RISE_MV);          // R6
   assign above_fall  = (core_regulator_output >= rst_pins_pkg::OK_FALL_MV);         // R7

   // A supply that drops restarts its own settle count
   always_comb begin
      mon_d = mon_q;
      if (regulator_input_supply) begin
         mon_d.ldo_cnt = sat_inc(mon_q.ldo_cnt, rst_pins_pkg::LDO_SETTLE_CYC);        // R6
      end else begin
         mon_d.ldo_cnt = '0;
      end
      if (analog_supply) begin
         mon_d.ana_cnt = sat_inc(mon_q.ana_cnt, rst_pins_pkg::ANA_SETTLE_CYC);        // R6
      end else begin
         mon_d.ana_cnt = '0;
      end
      if (!mon_q.supply_ok) begin
         mon_d.supply_ok = ldo_settled && ana_settled && above_rise;                  // R6
      end else begin
         // Lower threshold once high gives the hysteresis
         mon_d.supply_ok = regulator_input_supply && analog_supply && above_fall;     // R7
      end
   end

   // Cleared by the pin only: the reset it produces must not clear it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mon_q <= '0;
      end else begin
         mon_q <= mon_d;
      end
   end

   // Regulator disabled bypasses the comparator with no clock delay
   assign supply_ok_signal = core_regulator_enable_in ? 1'b1 : mon_q.supply_ok;   // R5 R9
   assign raw_rst_n        = resetn & supply_ok_signal;                           // R3 R4

   // Assert at once, release after two clean edges
   always_ff @(posedge clock or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= 1'b1;
         sync2_q <= sync1_q;
      end
   end
   assign hw_reset_n = sync2_q;                                                   // R20 R8

   // Sequencer runs from the synchronised hardware reset
   always_comb begin
      s_d          = s_q;
      s_d.step_cnt = s_q.step_cnt + 1'b1;
      s_d.clkout   = ~s_q.clkout;                                                 // R16
      case (s_q.seq)
         rst_pins_pkg::SEQ_RESET: begin
            s_d.seq      = rst_pins_pkg::SEQ_HIZ;
            s_d.step_cnt = 4'h1;
         end
         rst_pins_pkg::SEQ_HIZ: begin
            if (step_reached(s_q.step_cnt, rst_pins_pkg::PIN_HIZ_CYC)) begin       // R11
               s_d.seq       = rst_pins_pkg::SEQ_CLKGEN;
               s_d.clkgen_en = 1'b1;                                              // R10
            end
         end
         rst_pins_pkg::SEQ_CLKGEN: begin
            s_d.mem_cke = 1'b1;                                                   // R17
            if (step_reached(s_q.step_cnt, rst_pins_pkg::PIN_HIZ_CYC + rst_pins_pkg::CLKGEN_CYC)) begin
               s_d.seq = rst_pins_pkg::SEQ_BOOT;
            end
         end
         rst_pins_pkg::SEQ_BOOT: begin
            if (step_reached(s_q.step_cnt, rst_pins_pkg::BOOT_SAMPLE_CYC)) begin
               s_d.boot_mode = boot_mode_pins;                                    // R19
               s_d.boot_go   = 1'b1;                                              // R10 R8
               s_d.seq       = rst_pins_pkg::SEQ_RUN;
            end
         end
         rst_pins_pkg::SEQ_RUN: begin
            // Count parks here so it cannot wrap
            s_d.step_cnt = s_q.step_cnt;
         end
         default: begin
            s_d.seq = rst_pins_pkg::SEQ_RESET;
         end
      endcase
   end

   always_ff @(posedge clock or negedge hw_reset_n) begin
      if (!hw_reset_n) begin                                                      // R8
         s_q.seq       <= rst_pins_pkg::SEQ_RESET;
         s_q.step_cnt  <= '0;
         s_q.clkgen_en <= 1'b0;
         s_q.boot_go   <= 1'b0;
         s_q.boot_mode <= rst_pins_pkg::BOOT_RST;
         s_q.clkout    <= 1'b0;
         s_q.mem_cke   <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // RTC domain keeps its own reset; flag survives the chip reset
   always_ff @(posedge clock or negedge rtc_por_n) begin
      if (!rtc_por_n) begin
         rtc_lost_q <= 1'b1;                                                      // R12
      end else if (rtc_time_loaded) begin
         rtc_lost_q <= 1'b0;
      end
   end
   assign rtc_power_lost_flag = rtc_lost_q;

   // Soft resets never touch the hardware sequencer
   assign cpu_reset_n    = hw_reset_n & ~cpu_soft_reset;                          // R13
   assign periph_reset_n = {rst_pins_pkg::PERIPH_W{hw_reset_n}} & ~periph_soft_reset; // R13

   assign clkgen_enable = s_q.clkgen_en;
   assign boot_start    = s_q.boot_go;
   assign boot_mode     = s_q.boot_mode;

   // Pin enables are low-active; outputs float until the sequencer leaves Hi-Z
   logic pins_live;
   assign pins_live = (s_q.seq != rst_pins_pkg::SEQ_RESET) &&
                      (s_q.seq != rst_pins_pkg::SEQ_HIZ) && !core_power_lost_flag; // R11 R1

   always_comb begin
      pins.cs_hi_oe_n   = ~pins_live;                                             // R15
      pins.clkout_oe_n  = ~pins_live;                                             // R16
      pins.clkout       = s_q.clkout;                                             // R16
      pins.mem_cke_oe_n = ~pins_live;                                             // R17
      pins.mem_cke      = s_q.mem_cke;                                            // R17
      pins.mux_oe_n     = ~pins_live;                                             // R14
      pins.analog_oe_n  = 1'b1;                                                   // R18
   end

   assign ctl_pins_out                 = 1'b1;                                    // R15
   assign ctl_pins_oe_n                = pins.cs_hi_oe_n;
   assign clkout_pin                   = pins.clkout;
   assign clkout_pin_oe_n              = pins.clkout_oe_n;
   assign memory_clock_enable_pin      = pins.mem_cke;
   assign memory_clock_enable_pin_oe_n = pins.mem_cke_oe_n;
   assign analog_input_pins_oe_n       = pins.analog_oe_n;

   // Per-pin select: bit set picks the second peripheral
   always_comb begin
      for (int i = 0; i < rst_pins_pkg::MUX_W; i++) begin
         if (external_bus_select_reg[i]) begin
            mux_pin_out[i] = periph_b_out[i];                                     // R14
         end else begin
            mux_pin_out[i] = periph_a_out[i];                                     // R14
         end
      end
   end
   assign mux_pin_oe_n = periph_oe_n | {rst_pins_pkg::MUX_W{pins.mux_oe_n}};       // R14 R11

   assign bus_holder_en    = core_power_lost_flag;                                // R1
   assign pull_disable     = core_power_lost_flag;                                // R1
   // Exempt pins are powered separately, so loss of core power leaves them alone
   assign exempt_pins_oe_n = 1'b0;                                                // R2

endmodule

//--- sim/board_supply_model.sv
// Board side: reset source and supplies feeding the reset controller
`timescale 1ns/1ns
module board_supply_model (
   input  wire logic        clock,
   input  wire logic        reset_req,
   input  wire logic        use_regulator,
   input  wire logic [11:0] set_mv,
   output logic             resetn,
   output logic             core_regulator_enable_in,
   output logic             regulator_input_supply,
   output logic             analog_supply,
   output logic [11:0]      core_regulator_output
);
   // Board always drives the pin, so bypass mode is never left without reset
   assign resetn = !reset_req;
   assign core_regulator_enable_in = !use_regulator;
   assign regulator_input_supply = 1'b1;
   assign analog_supply = 1'b1;
   // Disabled regulator floats its output: shown as a changing pattern
   always @(posedge clock or posedge reset_req) begin
      if (reset_req) core_regulator_output <= 12'h000;
      else core_regulator_output <= use_regulator ? set_mv : ~core_regulator_output;
   end
endmodule

//--- sim/chip_reset_assertions.sv
// Checker: reset and pin-state relations at the controller ports
`timescale 1ns/1ns
module chip_reset_checker (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        core_regulator_enable_in,
   input wire logic        core_power_lost_flag,
   input wire logic [15:0] external_bus_select_reg,
   input wire logic [15:0] periph_a_out,
   input wire logic [15:0] periph_b_out,
   input wire logic        supply_ok_signal,
   input wire logic        hw_reset_n,
   input wire logic        clkgen_enable,
   input wire logic        boot_start,
   input wire logic [15:0] mux_pin_out,
   input wire logic [15:0] mux_pin_oe_n,
   input wire logic        ctl_pins_out,
   input wire logic        ctl_pins_oe_n,
   input wire logic        clkout_pin_oe_n,
   input wire logic        memory_clock_enable_pin,
   input wire logic        memory_clock_enable_pin_oe_n,
   input wire logic        analog_input_pins_oe_n,
   input wire logic        bus_holder_en,
   input wire logic        pull_disable,
   input wire logic        exempt_pins_oe_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_bypass_forces_ok: assert property (core_regulator_enable_in |-> supply_ok_signal) else $error("ok low");
   a_ok_gates_reset: assert property (!supply_ok_signal |-> !hw_reset_n) else $error("reset not held");
   a_release_synced: assert property ($rose(hw_reset_n) |-> $past(resetn && supply_ok_signal, 2)) else $error("early release");
   a_reset_pins_hiz: assert property (!hw_reset_n |-> ctl_pins_oe_n && clkout_pin_oe_n && (&mux_pin_oe_n)
      && memory_clock_enable_pin_oe_n) else $error("pin driven in reset");
   a_hiz_two_cycles: assert property ($rose(hw_reset_n) |-> ctl_pins_oe_n[*2]) else $error("pins early");
   a_analog_never_driven: assert property (analog_input_pins_oe_n) else $error("analog driven");
   a_power_loss_hold: assert property (core_power_lost_flag |-> bus_holder_en && pull_disable
      && ctl_pins_oe_n && (&mux_pin_oe_n)) else $error("power loss drive");
   a_exempt_kept: assert property (core_power_lost_flag |-> !exempt_pins_oe_n) else $error("exempt cut");
   a_group_high: assert property (!ctl_pins_oe_n |-> ctl_pins_out) else $error("group not high");
   a_cke_sync_rise: assert property ($rose(memory_clock_enable_pin)
      |-> !memory_clock_enable_pin_oe_n && $past(!memory_clock_enable_pin_oe_n)) else $error("cke rise");
   a_boot_after_clk: assert property ($rose(boot_start) |-> $past(clkgen_enable)) else $error("boot early");
   a_mux_select: assert property (hw_reset_n && !core_power_lost_flag |-> ((mux_pin_out ^
      ((external_bus_select_reg & periph_b_out) | (~external_bus_select_reg & periph_a_out))) & ~mux_pin_oe_n) == '0)
      else $error("mux wrong");
   c_boot: cover property ($rose(boot_start));
   c_loss: cover property (core_power_lost_flag);
   c_release: cover property ($rose(hw_reset_n));
endmodule
bind chip_reset_and_pin_state_control chip_reset_checker chip_reset_checker_i (
   .clock(clock), .resetn(resetn), .core_regulator_enable_in(core_regulator_enable_in),
   .core_power_lost_flag(core_power_lost_flag), .external_bus_select_reg(external_bus_select_reg),
   .periph_a_out(periph_a_out), .periph_b_out(periph_b_out), .supply_ok_signal(supply_ok_signal),
   .hw_reset_n(hw_reset_n), .clkgen_enable(clkgen_enable), .boot_start(boot_start),
   .mux_pin_out(mux_pin_out), .mux_pin_oe_n(mux_pin_oe_n), .ctl_pins_out(ctl_pins_out),
   .ctl_pins_oe_n(ctl_pins_oe_n), .clkout_pin_oe_n(clkout_pin_oe_n),
   .memory_clock_enable_pin(memory_clock_enable_pin),
   .memory_clock_enable_pin_oe_n(memory_clock_enable_pin_oe_n),
   .analog_input_pins_oe_n(analog_input_pins_oe_n), .bus_holder_en(bus_holder_en),
   .pull_disable(pull_disable), .exempt_pins_oe_n(exempt_pins_oe_n)
);

//--- sim/tb_chip_reset_and_pin_state_control.sv
// Testbench: reset sequencing, pin states, muxing and power loss
`timescale 1ns/1ns
module tb_chip_reset_and_pin_state_control;
   logic clock = 1'b0;
   logic reset_req, use_regulator, resetn, core_regulator_enable_in, regulator_input_supply, analog_supply;
   logic rtc_por_n, core_power_lost_flag, rtc_time_loaded, cpu_soft_reset;
   logic [11:0] set_mv, core_regulator_output;
   logic [rst_pins_pkg::PERIPH_W-1:0] periph_soft_reset, periph_reset_n;
   logic [rst_pins_pkg::MUX_W-1:0] external_bus_select_reg, periph_a_out, periph_b_out, periph_oe_n;
   logic [rst_pins_pkg::MUX_W-1:0] mux_pin_out, mux_pin_oe_n;
   logic [rst_pins_pkg::BOOT_W-1:0] boot_mode_pins, boot_mode;
   logic supply_ok_signal, hw_reset_n, cpu_reset_n, clkgen_enable, boot_start, rtc_power_lost_flag;
   logic ctl_pins_out, ctl_pins_oe_n, clkout_pin, clkout_pin_oe_n, memory_clock_enable_pin;
   logic memory_clock_enable_pin_oe_n, analog_input_pins_oe_n, bus_holder_en, pull_disable, exempt_pins_oe_n;
   int failures = 0;
   int tests_run = 0;
   always #25 clock = ~clock;
   board_supply_model board_supply_model_i (.*);
   chip_reset_and_pin_state_control chip_reset_and_pin_state_control_i (.*);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic t_boot();
      int n;
      logic ck;
      check("pins in reset", {ctl_pins_oe_n, clkout_pin_oe_n, memory_clock_enable_pin_oe_n, mux_pin_oe_n}, 19'h7_FFFF);
      check("idle", {hw_reset_n, clkgen_enable, boot_start}, 3'b000);
      reset_req = 0;
      n = 0;
      while (hw_reset_n !== 1'b1 && n < 10) begin step(1); n++; end
      check("release edges", n[15:0], 16'h0002);
      check("hiz after release", ctl_pins_oe_n, 1'b1);
      n = 0;
      while (clkgen_enable !== 1'b1 && n < 20) begin step(1); n++; end
      check("group high", {ctl_pins_oe_n, ctl_pins_out}, 2'b01);
      check("cke low driven", {memory_clock_enable_pin_oe_n, memory_clock_enable_pin, boot_start}, 3'b000);
      ck = clkout_pin;
      step(1);
      check("cke rise", memory_clock_enable_pin, 1'b1);
      check("clkout runs", {clkout_pin_oe_n, clkout_pin}, {1'b0, ~ck});
      while (boot_start !== 1'b1 && n < 40) begin step(1); n++; end
      check("boot mode", boot_mode, 6'h2D);
      boot_mode_pins = 6'h12;
      step(3);
      check("boot mode held", {boot_start, boot_mode}, 7'h6D);
   endtask
   task automatic t_mux();
      logic [15:0] sel [3] = '{16'h0000, 16'hFFFF, 16'h0F0F};
      logic [15:0] exp_out [3] = '{16'hA503, 16'h5A0C, 16'hAA0C};
      for (int i = 0; i < 3; i++) begin
         external_bus_select_reg = sel[i];
         step(1);
         check("mux out", mux_pin_out & ~periph_oe_n, exp_out[i]);
         check("mux oe", mux_pin_oe_n, periph_oe_n);
      end
      cpu_soft_reset = 1;
      periph_soft_reset = 8'h81;
      step(1);
      check("soft resets", {hw_reset_n, boot_start, cpu_reset_n, periph_reset_n}, 11'h67E);
      cpu_soft_reset = 0;
      periph_soft_reset = 8'h00;
      step(1);
      check("soft released", {cpu_reset_n, periph_reset_n}, 9'h1FF);
   endtask
   task automatic t_loss();
      core_power_lost_flag = 1;
      step(1);
      check("loss ctl", {bus_holder_en, pull_disable, ctl_pins_oe_n, exempt_pins_oe_n, analog_input_pins_oe_n}, 5'h1D);
      check("loss mux", mux_pin_oe_n, 16'hFFFF);
      core_power_lost_flag = 0;
      step(1);
      check("loss gone", {bus_holder_en, ctl_pins_oe_n}, 2'b00);
   endtask
   task automatic t_rtc();
      check("rtc flag set", rtc_power_lost_flag, 1'b1);
      rtc_time_loaded = 1;
      step(1);
      rtc_time_loaded = 0;
      step(1);
      check("rtc flag clear", rtc_power_lost_flag, 1'b0);
   endtask
   task automatic t_ldo();
      use_regulator = 1;
      set_mv = 12'h3E8;
      step(200);
      check("ok waits", {supply_ok_signal, hw_reset_n}, 2'b00);
      check("rtc kept", {rtc_power_lost_flag, ctl_pins_oe_n, clkgen_enable}, 3'b010);
      use_regulator = 0;
      #1;
      check("bypass ok", supply_ok_signal, 1'b1);
      step(4);
      check("reset pin only", hw_reset_n, 1'b1);
   endtask
   initial begin
      reset_req = 1; use_regulator = 0; set_mv = 12'h000; rtc_por_n = 0; rtc_time_loaded = 0;
      core_power_lost_flag = 0; cpu_soft_reset = 0; periph_soft_reset = 8'h00; boot_mode_pins = 6'h2D;
      external_bus_select_reg = 16'h0000; periph_a_out = 16'hA5C3; periph_b_out = 16'h5A3C; periph_oe_n = 16'h00F0;
      step(20);
      rtc_por_n = 1;
      t_boot();
      t_mux();
      t_loss();
      t_rtc();
      t_ldo();
      give_verdict();
   end
   // Whole run is a few hundred cycles; this span leaves wide margin
   initial begin
      #500000;
      failures++;
      give_verdict();
   end
endmodule
